// ===== hdl/ccsd_pkg.sv
// constants shared by the chip-select decode block and its helpers
// assumes a single 50 MHz mclk and a 20-bit processor address bus
package ccsd_pkg;
	localparam int ADDR_W = 20;
	localparam logic [19:0] BOOT_BASE = 20'h00000;
	localparam logic [19:0] BOOT_LAST = 20'h3ffff;
	localparam logic [19:0] DATA_BASE = 20'h40000;
	localparam logic [19:0] DATA_LAST = 20'h5ffff;
	localparam logic [19:0] NET_BASE = 20'h60000;
	localparam logic [19:0] NET_LAST = 20'h607ff;
	localparam int WS_W = 2;
	localparam logic [1:0] WAIT_BOOT = 2'h1;
	localparam logic [1:0] WAIT_DATA = 2'h0;
	localparam logic [1:0] WAIT_NET = 2'h2;
	// one wait state lasts one processor clock, 16.0 MHz at most
	localparam int CPU_CLK_KHZ = 16000;
	localparam int MCLK_KHZ = 50000;
	// least time, so round up
	localparam int TICK_CYCLES = (MCLK_KHZ + CPU_CLK_KHZ - 1) / CPU_CLK_KHZ;
	localparam int TICK_W = 3;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_EVENT = 8'h08;
	localparam logic [7:0] REG_COUNT = 8'h0c;
	localparam int CTRL_WIDE_BIT = 0;
	localparam int CTRL_ROM_OFF_BIT = 1;
	localparam int CTRL_EN_BIT = 2;
	localparam logic [2:0] CTRL_RESET = 3'h4;
	localparam int EV_UNMAPPED_BIT = 0;
	localparam int EV_BOOT_BIT = 1;
	localparam int EV_DATA_BIT = 2;
	localparam int EV_NET_BIT = 3;
	localparam logic [3:0] EVENT_RESET = 4'h0;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	typedef enum logic [1:0] {
		CCSD_IDLE = 2'b00,
		CCSD_WAIT = 2'b01,
		CCSD_READY = 2'b10,
		CCSD_HOLD = 2'b11
	} ccsd_state_t;
endpackage

// ===== hdl/ccsd_wait_if.sv
// handshake between the access sequencer and the wait-state counter
// assumes both ends run on the same mclk
interface ccsd_wait_if;
	import ccsd_pkg::*;
	logic start;
	logic [WS_W-1:0] states;
	logic done;
	modport seq (output start, output states, input done);
	modport cnt (input start, input states, output done);
endinterface

// ===== hdl/ccsd_region.sv
// address window comparator for one chip-select region
// assumes a synchronised address and strobe on the caller's clock
module ccsd_region #(
	parameter logic [19:0] BASE = 20'h00000,
	parameter logic [19:0] LAST = 20'h00000
) (
	input wire logic [19:0] addr,
	input wire logic strobe,
	output logic hit
);
	// inclusive bounds, gated by the strobe
	assign hit = strobe && (addr >= BASE) && (addr <= LAST);
endmodule // ccsd_region

// ===== hdl/ccsd_wait.sv
// wait-state counter: counts processor-clock ticks after a start pulse
// assumes start only while idle or finished; one tick is TICK_CYCLES mclk
module ccsd_wait (
	input wire logic mclk,
	input wire logic reset,
	ccsd_wait_if.cnt w
);
	import ccsd_pkg::*;
	logic busy_q;
	logic [WS_W-1:0] left_q;
	logic [TICK_W-1:0] div_q;
	wire tick = (div_q == TICK_W'(TICK_CYCLES - 1));
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			busy_q <= 1'b0;
			left_q <= '0;
			div_q <= '0;
		end else if (w.start) begin
			// divider restarts so every wait state is a full tick
			busy_q <= 1'b1;
			left_q <= w.states;
			div_q <= '0;
		end else if (busy_q && left_q != '0) begin
			div_q <= tick ? '0 : div_q + TICK_W'(1);
			if (tick) begin
				left_q <= left_q - WS_W'(1);
			end
		end else begin
			busy_q <= 1'b0;
		end
	end
	assign w.done = busy_q && (left_q == '0);
endmodule // ccsd_wait

// ===== hdl/ccsd_top.sv
// chip-select, wait-state and memory enable logic for the processor bus
// assumes asynchronous processor pins (synchronised here) and a classic
// wishbone master on mclk for the control registers
// Behaviour
// - boot select covers 00000h-3FFFFh with strobe and drives program memory enable low
// - boot region accesses take exactly one wait state
// - data RAM select covers 40000h-5FFFFh, 8-bit port (16-bit when the wide bit is set), both lanes, strobe gated
// - data RAM accesses take no wait state
// - network controller select covers 60000h-607FFh, 8-bit, strobe gated
// - network controller accesses take two wait states
// - high-byte RAM drives outputs only when reading and its enable is low
// - low-byte RAM drives outputs only when reading and third select enable is low
// - both RAMs write-enabled when read/write is low in a selected access
// - program memory output enable low normally; high disables its outputs
//
// Local design decisions: the Wishbone slave port and the register addresses.
module ccsd_top (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [ccsd_pkg::ADDR_W-1:0] cpu_addr,
	input wire logic address_strobe_n,
	input wire logic cpu_read,
	input wire logic cpu_upper_lane_n,
	input wire logic cpu_lower_lane_n,
	output logic cpu_ready_n,
	output logic program_memory_enable_n,
	output logic program_memory_output_enable_n,
	output logic network_controller_select_n,
	output logic high_byte_ram_enable_n,
	output logic low_byte_ram_enable_n,
	output logic high_ram_output_enable_n,
	output logic low_ram_output_enable_n,
	output logic ram_write_enable_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	import ccsd_pkg::*;

	// pin synchronisers: first stage feeds only the second
	logic [ADDR_W-1:0] addr_m_q, addr_s_q;
	logic [3:0] pins_m_q, pins_s_q;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			addr_m_q <= '0;
			addr_s_q <= '0;
		end else begin
			addr_m_q <= cpu_addr;
			addr_s_q <= addr_m_q;
		end
	end
	// strobe and lanes turned active high before the first stage
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pins_m_q <= 4'h0;
			pins_s_q <= 4'h0;
		end else begin
			pins_m_q <= {~address_strobe_n, cpu_read, ~cpu_upper_lane_n, ~cpu_lower_lane_n};
			pins_s_q <= pins_m_q;
		end
	end
	// address is set up before the strobe, so it has settled by the
	// time the synchronised strobe is seen
	wire strobe_s = pins_s_q[3];
	wire read_s = pins_s_q[2];
	wire upper_s = pins_s_q[1];
	wire lower_s = pins_s_q[0];

	// control register
	logic [2:0] ctrl_q, ctrl_d;
	wire wide_ram = ctrl_q[CTRL_WIDE_BIT];
	wire rom_off = ctrl_q[CTRL_ROM_OFF_BIT];
	wire decode_en = ctrl_q[CTRL_EN_BIT];

	// region decode
	logic hit_boot, hit_data, hit_net;
	wire dec_strobe = strobe_s && decode_en;
	ccsd_region #(.BASE(BOOT_BASE), .LAST(BOOT_LAST)) u_boot (
		.addr(addr_s_q),
		.strobe(dec_strobe),
		.hit(hit_boot)
	);
	ccsd_region #(.BASE(DATA_BASE), .LAST(DATA_LAST)) u_data (
		.addr(addr_s_q),
		.strobe(dec_strobe),
		.hit(hit_data)
	);
	ccsd_region #(.BASE(NET_BASE), .LAST(NET_LAST)) u_net (
		.addr(addr_s_q),
		.strobe(dec_strobe),
		.hit(hit_net)
	);
	// windows are disjoint; priority keeps one select even if they were not
	wire sel_boot = hit_boot;
	wire sel_data = hit_data && !hit_boot;
	wire sel_net = hit_net && !hit_boot && !hit_data;
	wire any_hit = hit_boot || hit_data || hit_net;
	wire [WS_W-1:0] ws_sel = sel_boot ? WAIT_BOOT :
		sel_data ? WAIT_DATA : WAIT_NET;

	// wait-state counter
	ccsd_wait_if wif ();
	ccsd_wait u_wait (
		.mclk(mclk),
		.reset(reset),
		.w(wif.cnt)
	);

	// access sequencer
	ccsd_state_t state_q, state_d;
	logic boot_q, data_q, net_q, read_q, upper_q, lower_q, ready_q;
	wire start = (state_q == CCSD_IDLE) && dec_strobe && any_hit;
	wire miss = (state_q == CCSD_IDLE) && dec_strobe && !any_hit;
	assign wif.start = start;
	assign wif.states = ws_sel;
	always_comb begin
		state_d = state_q;
		case (state_q)
			CCSD_IDLE: begin
				if (start) begin
					state_d = CCSD_WAIT;
				end else if (miss) begin
					state_d = CCSD_HOLD;
				end
			end
			CCSD_WAIT: begin
				if (!strobe_s) begin
					state_d = CCSD_IDLE;
				end else if (wif.done) begin
					state_d = CCSD_READY;
				end
			end
			CCSD_READY, CCSD_HOLD: begin
				if (!strobe_s) begin
					state_d = CCSD_IDLE;
				end
			end
			default: state_d = CCSD_IDLE;
		endcase
	end
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_q <= CCSD_IDLE;
		end else begin
			state_q <= state_d;
		end
	end
	// selects held from decode until the strobe falls
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			boot_q <= 1'b0;
			data_q <= 1'b0;
			net_q <= 1'b0;
		end else if (start) begin
			boot_q <= sel_boot;
			data_q <= sel_data;
			net_q <= sel_net;
		end else if (state_d == CCSD_IDLE) begin
			boot_q <= 1'b0;
			data_q <= 1'b0;
			net_q <= 1'b0;
		end
	end
	// direction idles as read so no write enable can leak between accesses
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			read_q <= 1'b1;
			upper_q <= 1'b0;
			lower_q <= 1'b0;
		end else if (start) begin
			read_q <= read_s;
			upper_q <= upper_s;
			lower_q <= lower_s;
		end else if (state_d == CCSD_IDLE) begin
			read_q <= 1'b1;
			upper_q <= 1'b0;
			lower_q <= 1'b0;
		end
	end
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ready_q <= 1'b0;
		end else begin
			ready_q <= (state_d == CCSD_READY);
		end
	end
	assign cpu_ready_n = ~ready_q;

	// memory enables
	// a narrow board has one RAM on the high enable, any lane selects it
	wire data_hi = data_q && (wide_ram ? upper_q : (upper_q || lower_q));
	wire third_chip_select = data_q && wide_ram && lower_q;
	assign program_memory_enable_n = ~boot_q;
	assign program_memory_output_enable_n = rom_off;
	assign network_controller_select_n = ~net_q;
	assign high_byte_ram_enable_n = ~data_hi;
	assign low_byte_ram_enable_n = ~third_chip_select;
	assign high_ram_output_enable_n = ~(read_q && data_hi);
	assign low_ram_output_enable_n = ~(read_q && third_chip_select);
	assign ram_write_enable_n = ~(!read_q && data_q);

	// wishbone slave, answers every request one cycle later
	logic ack_q;
	logic [3:0] event_q, event_d;
	logic [15:0] count_q;
	logic [31:0] rdata_q, rdata_d;
	wire req = wb_cyc_i && wb_stb_i && !ack_q;
	// a write lands only on the edge at which the master sees ack
	wire wr = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0];
	wire hit_ctrl = (wb_adr_i == REG_CTRL);
	wire hit_status = (wb_adr_i == REG_STATUS);
	wire hit_event = (wb_adr_i == REG_EVENT);
	wire hit_count = (wb_adr_i == REG_COUNT);
	wire wr_ctrl = wr && hit_ctrl;
	wire wr_event = wr && hit_event;
	logic [3:0] ev_set;
	always_comb begin
		ev_set = 4'h0;
		ev_set[EV_UNMAPPED_BIT] = miss;
		ev_set[EV_BOOT_BIT] = start && sel_boot;
		ev_set[EV_DATA_BIT] = start && sel_data;
		ev_set[EV_NET_BIT] = start && sel_net;
	end
	wire [3:0] ev_clr = wr_event ? wb_dat_i[3:0] : 4'h0;
	wire [31:0] status_w = {24'h000000, state_q, read_q, ready_q, net_q, data_q, boot_q, strobe_s};
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctrl) begin
			ctrl_d = wb_dat_i[2:0];
		end
		// set wins over a write-one clear in the same cycle
		event_d = (event_q & ~ev_clr) | ev_set;
		rdata_d = 32'h00000000;
		if (hit_ctrl) begin
			rdata_d = {29'h00000000, ctrl_q};
		end else if (hit_status) begin
			rdata_d = status_w;
		end else if (hit_event) begin
			rdata_d = {28'h0000000, event_q};
		end else if (hit_count) begin
			rdata_d = {16'h0000, count_q};
		end
	end
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req;
		end
	end
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ctrl_q <= CTRL_RESET;
			event_q <= EVENT_RESET;
		end else begin
			ctrl_q <= ctrl_d;
			event_q <= event_d;
		end
	end
	// wraps silently; software works with differences
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			count_q <= COUNT_RESET;
		end else if (start) begin
			count_q <= count_q + 16'h0001;
		end
	end
	// captured when the request is taken, stands through ack
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rdata_q <= 32'h00000000;
		end else if (req) begin
			rdata_q <= rdata_d;
		end
	end
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdata_q;
endmodule // ccsd_top

// ===== sim/ccsd_asserts.sv
// pin-level assertions for the chip-select decode top
// assumes only the top's ports, one mclk domain
module ccsd_asserts (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [19:0] cpu_addr,
	input wire logic cpu_ready_n,
	input wire logic program_memory_enable_n,
	input wire logic network_controller_select_n,
	input wire logic high_byte_ram_enable_n,
	input wire logic low_byte_ram_enable_n,
	input wire logic high_ram_output_enable_n,
	input wire logic low_ram_output_enable_n,
	input wire logic ram_write_enable_n
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking dc @(posedge mclk); endclocking
	default disable iff (reset);
	wire logic pm = !program_memory_enable_n;
	wire logic nt = !network_controller_select_n;
	wire logic dt = !high_byte_ram_enable_n || !low_byte_ram_enable_n;
	one_select_a: assert property (pm + nt + dt <= 2'd1) else $error("two selects");
	boot_range_a: assert property (pm |-> cpu_addr <= 20'h3ffff) else $error("boot addr");
	data_range_a: assert property (dt |-> cpu_addr inside {[20'h40000:20'h5ffff]}) else $error("data addr");
	net_range_a: assert property (nt |-> cpu_addr inside {[20'h60000:20'h607ff]}) else $error("net addr");
	boot_wait_a: assert property ($rose(pm) |-> cpu_ready_n [*4] ##[1:2] !cpu_ready_n) else $error("boot wait");
	data_wait_a: assert property ($rose(dt) |-> ##[0:1] !cpu_ready_n) else $error("data wait");
	net_wait_a: assert property ($rose(nt) |-> cpu_ready_n [*8] ##[1:2] !cpu_ready_n) else $error("net wait");
	high_oe_a: assert property (!high_ram_output_enable_n |-> !high_byte_ram_enable_n && ram_write_enable_n)
		else $error("high oe");
	low_oe_a: assert property (!low_ram_output_enable_n |-> !low_byte_ram_enable_n && ram_write_enable_n)
		else $error("low oe");
	write_en_a: assert property (!ram_write_enable_n |-> dt) else $error("write enable");
	cover property ($rose(pm));
	cover property ($rose(nt));
	cover property ($rose(!low_byte_ram_enable_n));
endmodule // ccsd_asserts
bind ccsd_top ccsd_asserts u_chk (.mclk, .reset, .cpu_addr, .cpu_ready_n, .program_memory_enable_n,
	.network_controller_select_n, .high_byte_ram_enable_n, .low_byte_ram_enable_n, .high_ram_output_enable_n,
	.low_ram_output_enable_n, .ram_write_enable_n);

// ===== sim/ccsd_mem_model.sv
// far-side program memory, RAMs and network chip as lane drivers
// assumes enables straight from the top's pins
module ccsd_mem_model (
	input wire logic mclk,
	input wire logic program_memory_enable_n,
	input wire logic program_memory_output_enable_n,
	input wire logic network_controller_select_n,
	input wire logic cpu_read,
	input wire logic high_ram_output_enable_n,
	input wire logic low_ram_output_enable_n,
	output int clash_count
);
	timeunit 1ns;
	timeprecision 1ns;
	// ROM and network chip drive only while cpu_read is high, RAMs on their output enables, so any overlap is a real clash
	wire logic rom = !program_memory_enable_n && !program_memory_output_enable_n && cpu_read;
	wire logic net = !network_controller_select_n && cpu_read;
	initial clash_count = 0;
	always @(posedge mclk) begin
		if (rom + !high_ram_output_enable_n > 2'd1 || rom + net + !low_ram_output_enable_n > 2'd1)
			clash_count++;
	end
endmodule // ccsd_mem_model

// ===== sim/controller_chip_select_decode_bench.sv
// self-checking bench for the chip-select decode top
// assumes processor pins, wishbone and far-side model all on mclk
module controller_chip_select_decode_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0, reset = 1, address_strobe_n = 1, cpu_read = 1, cpu_upper_lane_n = 1, cpu_lower_lane_n = 1;
	logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wide = 0;
	logic [19:0] cpu_addr = 0;
	logic [7:0] wb_adr_i = 0;
	logic [3:0] wb_sel_i = 0;
	logic [31:0] wb_dat_i = 0, wb_dat_o, q;
	logic cpu_ready_n, program_memory_enable_n, program_memory_output_enable_n, network_controller_select_n;
	logic high_byte_ram_enable_n, low_byte_ram_enable_n, high_ram_output_enable_n, low_ram_output_enable_n;
	logic ram_write_enable_n, wb_ack_o;
	logic [19:0] edges [8] = '{20'h0, 20'h3ffff, 20'h40000, 20'h5ffff, 20'h60000, 20'h607ff, 20'h60800, 20'hfffff};
	int fail_count = 0, cmp_count = 0, hits = 0, clash_count, r, m, i;
	wire logic [6:0] outs = {program_memory_enable_n, network_controller_select_n, high_byte_ram_enable_n,
		low_byte_ram_enable_n, high_ram_output_enable_n, low_ram_output_enable_n, ram_write_enable_n};
	initial forever #10 mclk = ~mclk;
	ccsd_top i_dut (.mclk, .reset, .cpu_addr, .address_strobe_n, .cpu_read, .cpu_upper_lane_n, .cpu_lower_lane_n,
		.cpu_ready_n, .program_memory_enable_n, .program_memory_output_enable_n, .network_controller_select_n,
		.high_byte_ram_enable_n, .low_byte_ram_enable_n, .high_ram_output_enable_n, .low_ram_output_enable_n,
		.ram_write_enable_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
	ccsd_mem_model i_mem (.mclk, .program_memory_enable_n, .program_memory_output_enable_n,
		.network_controller_select_n, .cpu_read, .high_ram_output_enable_n, .low_ram_output_enable_n, .clash_count);
	task automatic check(input string what, input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			$display("BAD %s expected %h seen %h", what, exp, seen);
			fail_count++;
		end
	endtask
	task automatic print_verdict;
		if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, 4'hf};
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		if (n == 20) begin
			fail_count++;
			print_verdict;
		end
	endtask
	function automatic logic [19:0] pick(int r);
		case (r)
			0: pick = 20'($urandom_range(32'h3ffff, 0));
			1: pick = 20'($urandom_range(32'h5ffff, 32'h40000));
			2: pick = 20'($urandom_range(32'h607ff, 32'h60000));
			default: pick = 20'($urandom_range(32'hfffff, 32'h60800));
		endcase
	endfunction
	// lanes are active low; narrow board routes every lane to the high enable
	function automatic logic [6:0] exp_outs(int r, logic rd, logic [1:0] ln);
		logic hb, lb;
		hb = r == 1 && (!wide || !ln[1]);
		lb = r == 1 && wide && !ln[0];
		return ~{r == 0, r == 2, hb, lb, hb && rd, lb && rd, r == 1 && !rd};
	endfunction
	task automatic access(input int r, input logic [19:0] a);
		logic rd;
		logic [1:0] ln;
		int n;
		rd = 1'($urandom);
		ln = 2'($urandom_range(2, 0));
		if (r != 3) hits++;
		@(posedge mclk);
		{cpu_addr, cpu_read, cpu_upper_lane_n, cpu_lower_lane_n} <= {a, rd, ln};
		@(posedge mclk);
		address_strobe_n <= 0;
		n = 0;
		do begin
			@(posedge mclk);
			#1 n++;
		end while (cpu_ready_n !== 1'b0 && n < 24);
		if (r == 3) check("unmapped", {cpu_ready_n, outs}, 8'hff);
		else begin
			check("latency", n, 4 + 4 * (r == 0 ? 1 : r == 2 ? 2 : 0));
			check("selects", outs, exp_outs(r, rd, ln));
			if (n == 24) print_verdict;
		end
		@(posedge mclk);
		address_strobe_n <= 1;
		repeat (5) @(posedge mclk);
	endtask
	initial begin
		void'($urandom(32'h8ce8db4e));
		repeat (5) @(posedge mclk);
		reset <= 0;
		#1 check("rom oe", program_memory_output_enable_n, 0);
		wb(0, 8'h00, 0);
		check("ctrl", q, 32'h4);
		wb(0, 8'h30, 0);
		check("no reg", q, 0);
		// decode off: even a data address must select nothing
		wb(1, 8'h00, 32'h0);
		access(3, edges[2]);
		wb(1, 8'h00, 32'h6);
		#1 check("rom off", program_memory_output_enable_n, 1);
		for (m = 0; m < 2; m++) begin
			wide = m[0];
			wb(1, 8'h00, {29'h0, 2'b10, wide});
			for (i = 0; i < 8; i++) access(i / 2, edges[i]);
			repeat (30) begin
				r = $urandom_range(3, 0);
				access(r, pick(r));
			end
		end
		check("clash", clash_count, 0);
		wb(0, 8'h0c, 0);
		check("count", q, hits);
		wb(0, 8'h08, 0);
		check("events", q, 32'hf);
		wb(1, 8'h08, 32'hf);
		wb(0, 8'h08, 0);
		check("event clr", q, 0);
		print_verdict;
	end
endmodule // controller_chip_select_decode_bench
